/* src/reset_source_combiner.sv */
// reset source combiner: or-ing of sources, warm-up sequencing, cause status
`timescale 1ns/1ps
module reset_source_combiner #(
    parameter int WARMUP_CYCLES = reset_source_combiner_pkg::WARMUP_CYCLES_DEFAULT
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // analog power-on detector, asynchronous, high while supply is low
    input wire logic porDetect,
    // shared reset/port pin, asynchronous, active low as reset
    input wire logic resetPinRaw,
    // internal factor events, same clock
    input wire logic vdetTrip,
    input wire logic wdtOverflow,
    input wire logic clkDeadlock,
    input wire logic trimCorrupt,
    input wire logic flashStandbyAccess,
    // trim loader result, same clock, valid at warm-up end
    input wire logic trimLoadBad,
    // register port
    input wire logic [reset_source_combiner_pkg::REG_ADDR_W-1:0] regAddr,
    input wire logic [reset_source_combiner_pkg::REG_DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [reset_source_combiner_pkg::REG_DATA_W-1:0] regRdata,
    // reset outputs
    output logic cpuResetN,
    output logic periphResetN,
    output logic warmupActive,
    output logic trimLoadStart,
    output logic [15:0] startVector,
    // pin used as port bit
    output logic portPinData
);
    import reset_source_combiner_pkg::*;

    localparam int WCNT_W = $clog2(WARMUP_CYCLES + 1);
    localparam logic [WCNT_W-1:0] WCNT_LAST = WCNT_W'(WARMUP_CYCLES - 1);

    //======================================================================
    // declarations
    //======================================================================
    logic porA_reg;
    logic porB_reg;
    logic pinLevel;
    logic pinLowQualified;
    logic pinDisabled_reg;
    logic disPending_reg;
    logic clrReq_reg;
    logic trimErr_reg;
    logic [NUM_FACTORS-1:0] cause_reg;
    logic [NUM_FACTORS-1:0] factorEvt;
    logic anyFactor;
    logic pinReset;
    logic powerReset;
    logic anyReset;
    logic keyWrite;
    logic clearCauses;
    seq_state_t state_reg;
    seq_state_t state_next;
    logic [WCNT_W-1:0] warmCnt_reg;
    logic warmDone;
    logic [REG_DATA_W-1:0] rdata_reg;
    logic [REG_DATA_W-1:0] rdMux;
    logic cpuResetN_reg;
    logic periphResetN_reg;
    logic warmupActive_reg;
    logic trimLoadStart_reg;
    logic [15:0] startVector_reg;
    logic portPinData_reg;

    //======================================================================
    // source qualification
    //======================================================================
    // detector output crosses in through two flops before use
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            porA_reg <= 1'b1;
            porB_reg <= 1'b1;
        end else begin
            porA_reg <= porDetect;
            porB_reg <= porA_reg;
        end
    end

    reset_pin_filter #(
        .LOW_MIN_CYCLES(PIN_LOW_MIN_CYCLES)
    ) u_pin_filter (
        .clock(clock),
        .rst_n(rst_n),
        .pinRaw(resetPinRaw),
        .pinLevel(pinLevel),
        .pinLowQualified(pinLowQualified)
    );

    // factor events in cause-bit order
    assign factorEvt[BIT_VDET] = vdetTrip;
    assign factorEvt[BIT_WDT] = wdtOverflow;
    assign factorEvt[BIT_SYSCLK] = clkDeadlock;
    assign factorEvt[BIT_TRIM] = trimCorrupt && state_reg == ST_RUN;
    assign factorEvt[BIT_FLASH] = flashStandbyAccess;
    assign anyFactor = |factorEvt;

    // the pin only resets while it is in reset function; once in reset any low level
    // holds it there, so warm-up waits for the later of pin and power-on release
    assign pinReset = (pinLowQualified || (!pinLevel && state_reg == ST_RESET))
        && !pinDisabled_reg;
    assign powerReset = porB_reg;
    assign anyReset = powerReset || pinReset || anyFactor;

    //======================================================================
    // warm-up sequencer
    //======================================================================
    assign warmDone = warmCnt_reg == WCNT_LAST;

    // next state; any source drops the sequencer back to reset
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: begin
                if (!anyReset) begin
                    state_next = ST_WARMUP; // last source released
                end
            end
            ST_WARMUP: begin
                if (anyReset) begin
                    state_next = ST_RESET; // abort and restart later
                end else if (warmDone) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (anyReset) begin
                    state_next = ST_RESET;
                end
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // counter is held at zero outside warm-up so every restart is full length
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            warmCnt_reg <= '0;
        end else if (state_reg != ST_WARMUP || anyReset) begin
            warmCnt_reg <= '0;
        end else if (!warmDone) begin
            warmCnt_reg <= warmCnt_reg + 1'b1;
        end
    end

    // reset outputs registered from the next state so they track it exactly
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cpuResetN_reg <= 1'b0;
            periphResetN_reg <= 1'b0;
            warmupActive_reg <= 1'b0;
            trimLoadStart_reg <= 1'b0;
            startVector_reg <= RESET_VECTOR_ADDR;
        end else begin
            cpuResetN_reg <= state_next == ST_RUN;
            periphResetN_reg <= state_next == ST_RUN;
            warmupActive_reg <= state_next == ST_WARMUP;
            trimLoadStart_reg <= state_reg == ST_RESET && state_next == ST_WARMUP;
            startVector_reg <= RESET_VECTOR_ADDR;
        end
    end

    //======================================================================
    // trim error flag
    //======================================================================
    // sampled once per warm-up; holds until the next warm-up completes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            trimErr_reg <= 1'b0;
        end else if (state_reg == ST_WARMUP && state_next == ST_RUN) begin
            trimErr_reg <= trimLoadBad;
        end
    end

    //======================================================================
    // register port
    //======================================================================
    assign keyWrite = regWr && regAddr == OFF_PROTECT_KEY;
    assign clearCauses = keyWrite && regWdata == KEY_CAUSE_CLEAR && clrReq_reg;

    // cause flags: power or pin reset wipes them; a new event beats a clear
    always_ff @(posedge clock) begin
        if (!rst_n || powerReset || pinReset) begin
            cause_reg <= CAUSE_RESET_VAL;
        end else begin
            cause_reg <= (clearCauses ? CAUSE_RESET_VAL : cause_reg) | factorEvt;
        end
    end

    // clear request: written directly, consumed by the matching key
    always_ff @(posedge clock) begin
        if (!rst_n || powerReset || pinReset) begin
            clrReq_reg <= 1'b0;
        end else if (clearCauses) begin
            clrReq_reg <= 1'b0; // self-clears after use
        end else if (regWr && regAddr == OFF_CAUSE_STATUS) begin
            clrReq_reg <= regWdata[BIT_CLR_REQ];
        end
    end

    // pin disable: staged bit takes effect only on the pin-function key
    always_ff @(posedge clock) begin
        if (!rst_n || powerReset) begin
            disPending_reg <= 1'b0;
            pinDisabled_reg <= 1'b0; // reset function after power-up
        end else begin
            if (regWr && regAddr == OFF_SYS_CTL_THREE) begin
                disPending_reg <= regWdata[BIT_PIN_DIS];
            end
            if (keyWrite && regWdata == KEY_PIN_FUNCTION) begin
                pinDisabled_reg <= disPending_reg;
            end
        end
    end

    // read mux; key register and unmapped addresses read zero
    always_comb begin
        rdMux = '0;
        case (regAddr)
            OFF_CAUSE_STATUS: begin
                rdMux[NUM_FACTORS-1:0] = cause_reg;
                rdMux[BIT_TRIM_ERR] = trimErr_reg;
                rdMux[BIT_CLR_REQ] = clrReq_reg;
                rdMux[7] = 1'b0;
            end
            OFF_SYS_CTL_THREE: begin
                rdMux[BIT_PIN_DIS] = disPending_reg;
            end
            default: begin
                rdMux = '0;
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else if (regRd) begin
            rdata_reg <= rdMux;
        end else begin
            rdata_reg <= '0;
        end
    end

    // port view of the pin, meaningful only while disabled as reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            portPinData_reg <= 1'b0;
        end else begin
            portPinData_reg <= pinDisabled_reg && pinLevel;
        end
    end

    assign regRdata = rdata_reg;
    assign cpuResetN = cpuResetN_reg;
    assign periphResetN = periphResetN_reg;
    assign warmupActive = warmupActive_reg;
    assign trimLoadStart = trimLoadStart_reg;
    assign startVector = startVector_reg;
    assign portPinData = portPinData_reg;

    //======================================================================
    // checks
    //======================================================================
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_clear_armed;
        clrReq_reg && !powerReset && !pinReset;
    endsequence

    sequence s_clear_key;
        keyWrite && regWdata == 8'h71 && factorEvt == 5'h00;
    endsequence

    sequence s_warmup_run;
        state_reg == ST_WARMUP && !anyReset && warmDone;
    endsequence

    AST_POR_HOLDS: assert property (
        powerReset |=> state_reg == ST_RESET && !cpuResetN)
        else $error("power-on reset did not hold reset");

    AST_PIN_HOLDS: assert property (
        pinReset |=> state_reg == ST_RESET && !periphResetN)
        else $error("pin reset did not hold reset");

    AST_PIN_HOLDS_RELEASE: assert property (
        (state_reg == ST_RESET && !pinLevel && !pinDisabled_reg) |=> state_reg == ST_RESET)
        else $error("warm-up started while the pin was still low");

    AST_WARMUP_START: assert property (
        (state_reg == ST_RESET && !anyReset) |=> state_reg == ST_WARMUP && trimLoadStart)
        else $error("warm-up did not start at last release");

    AST_RUN_AFTER_WARMUP: assert property (
        $rose(cpuResetN) |-> $past(state_reg) == ST_WARMUP && $past(warmCnt_reg) == WCNT_LAST)
        else $error("cpu released before warm-up finished");

    AST_WARMUP_ABORT: assert property (
        (state_reg == ST_WARMUP && anyReset) |=> state_reg == ST_RESET && warmCnt_reg == 0)
        else $error("reset during warm-up did not restart it");

    AST_FACTOR_FLAG: assert property (
        (anyFactor && !powerReset && !pinReset) |=> (cause_reg & $past(factorEvt))
            == $past(factorEvt) && state_reg == ST_RESET)
        else $error("factor event lost its flag or reset");

    AST_CAUSE_CLEAR: assert property (
        s_clear_armed ##0 s_clear_key |=> cause_reg == 5'h00 && !clrReq_reg)
        else $error("key 0x71 did not clear causes");

    AST_PIN_FUNCTION: assert property (
        (keyWrite && regWdata == 8'hb2 && !powerReset) |=> pinDisabled_reg == $past(disPending_reg))
        else $error("key 0xb2 did not apply pin function");

    AST_BIT7_ZERO: assert property (
        regRd |=> !regRdata[7])
        else $error("bit 7 of cause status read as one");

    AST_TRIM_FLAG: assert property (
        s_warmup_run |=> trimErr_reg == $past(trimLoadBad) ##1 cpuResetN)
        else $error("trim error flag not captured at warm-up end");

    AST_VECTOR: assert property (
        $rose(cpuResetN) |-> startVector == 16'hfffe)
        else $error("start vector wrong at release");

    AST_POWER_PIN_RESTORE: assert property (
        powerReset |=> !pinDisabled_reg)
        else $error("pin not in reset function after power-up");
endmodule // reset_source_combiner

/* src/reset_source_combiner_pkg.sv */
// constants, register map and state codes for the reset source combiner
//==========================================================================
package reset_source_combiner_pkg;
    // register port
    localparam int REG_ADDR_W = 4;
    localparam int REG_DATA_W = 8;
    localparam logic [3:0] OFF_CAUSE_STATUS = 4'h0;
    localparam logic [3:0] OFF_SYS_CTL_THREE = 4'h1;
    localparam logic [3:0] OFF_PROTECT_KEY = 4'h2;
    // cause status fields, and the OFF_SYS_CTL_THREE pin-disable bit
    localparam int NUM_FACTORS = 5;
    localparam int BIT_VDET = 0;
    localparam int BIT_WDT = 1;
    localparam int BIT_SYSCLK = 2;
    localparam int BIT_TRIM = 3;
    localparam int BIT_FLASH = 4;
    localparam int BIT_TRIM_ERR = 5;
    localparam int BIT_CLR_REQ = 6;
    localparam int BIT_PIN_DIS = 0;
    // protect key codes
    localparam logic [7:0] KEY_CAUSE_CLEAR = 8'h71;
    localparam logic [7:0] KEY_PIN_FUNCTION = 8'hb2;
    // reset values
    localparam logic [NUM_FACTORS-1:0] CAUSE_RESET_VAL = 5'h00;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int PIN_LOW_MIN_NS = 5000;
    localparam int PIN_LOW_MIN_CYCLES = (PIN_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WARMUP_CYCLES_DEFAULT = 2048;
    // sequencer states
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_WARMUP = 2'b01,
        ST_RUN = 2'b10
    } seq_state_t;
endpackage

/* src/reset_pin_filter.sv */
// reset pin synchroniser and minimum-low-width qualifier
`timescale 1ns/1ps
module reset_pin_filter #(
    parameter int LOW_MIN_CYCLES = reset_source_combiner_pkg::PIN_LOW_MIN_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // raw pin level, asynchronous
    input wire logic pinRaw,
    // qualified outputs
    output logic pinLevel,
    output logic pinLowQualified
);
    import reset_source_combiner_pkg::*;

    localparam int CNT_W = $clog2(LOW_MIN_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(LOW_MIN_CYCLES - 1);

    logic syncA_reg;
    logic syncB_reg;
    logic [CNT_W-1:0] lowCnt_reg;
    logic lowQual_reg;

    // two-flop synchroniser; the first stage feeds only the second
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            syncA_reg <= 1'b1;
            syncB_reg <= 1'b1;
        end else begin
            syncA_reg <= pinRaw;
            syncB_reg <= syncA_reg;
        end
    end

    // count low cycles; short glitches below the minimum are dropped
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lowCnt_reg <= '0;
            lowQual_reg <= 1'b0;
        end else if (syncB_reg) begin
            lowCnt_reg <= '0;
            lowQual_reg <= 1'b0; // release on the rising edge
        end else if (lowCnt_reg == CNT_MAX) begin
            lowQual_reg <= 1'b1; // held low for the full minimum
        end else begin
            lowCnt_reg <= lowCnt_reg + 1'b1;
        end
    end

    assign pinLevel = syncB_reg;
    assign pinLowQualified = lowQual_reg;

    AST_PIN_QUALIFY: assert property (@(posedge clock) disable iff (!rst_n)
        (!syncB_reg && lowCnt_reg == CNT_MAX) |=> lowQual_reg)
        else $error("pin low for minimum width did not assert reset");
endmodule // reset_pin_filter

/* verification/board_reset_model.sv */
// board-side model: reset pin with pull-up and the analog power-on detector
`timescale 1ns/1ps
module board_reset_model (
    // clock
    input wire logic clock,
    // lines driven toward the block
    output logic pinLine,
    output logic porLine
);
    //==============================================================
    // idle levels
    // the pull-up keeps the pin high whenever nobody pulls it down
    initial begin
        pinLine = 1'b1;
        porLine = 1'b0;
    end
    //==============================================================
    // actions
    // supply and oscillator are taken as stable, so the low time is the only figure
    task automatic hold_pin_low(input int cycles);
        @(posedge clock);
        pinLine <= 1'b0;
        repeat (cycles) @(posedge clock);
        pinLine <= 1'b1;
    endtask
    // supply dip below the detection level
    task automatic supply_dip(input int cycles);
        @(posedge clock);
        porLine <= 1'b1;
        repeat (cycles) @(posedge clock);
        porLine <= 1'b0;
    endtask
endmodule // board_reset_model

/* verification/reset_source_combiner_tb.sv */
// self-checking bench for the reset source combiner
`timescale 1ns/1ps
module reset_source_combiner_tb;
    import reset_source_combiner_pkg::*;
    //==============================================================
    // signals
    localparam int WARM = 16; // short warm-up keeps the run brief
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic pinLine;
    logic porLine;
    logic vdetIn = 1'b0, wdtIn = 1'b0, lockIn = 1'b0, trimIn = 1'b0, flashIn = 1'b0;
    logic trimLoadBad = 1'b0;
    logic [REG_ADDR_W-1:0] regAddr = 4'h0;
    logic [REG_DATA_W-1:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [REG_DATA_W-1:0] regRdata;
    logic cpuResetN, periphResetN, warmupActive, trimLoadStart, portPinData;
    logic [15:0] startVector;
    int err_count = 0;
    int checks_done = 0;
    int loads = 0;
    int n;
    // 125 MHz clock
    always #4 clock = ~clock;
    //==============================================================
    // instances
    board_reset_model partner (.clock(clock), .pinLine(pinLine), .porLine(porLine));
    reset_source_combiner #(.WARMUP_CYCLES(WARM)) DUT (
        .clock(clock), .rst_n(rst_n), .porDetect(porLine), .resetPinRaw(pinLine),
        .vdetTrip(vdetIn), .wdtOverflow(wdtIn), .clkDeadlock(lockIn),
        .trimCorrupt(trimIn), .flashStandbyAccess(flashIn), .trimLoadBad(trimLoadBad),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .cpuResetN(cpuResetN), .periphResetN(periphResetN),
        .warmupActive(warmupActive), .trimLoadStart(trimLoadStart),
        .startVector(startVector), .portPinData(portPinData));
    //==============================================================
    // tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        chk({8'h00, regRdata}, {8'h00, exp});
    endtask
    // factor event lines addressed by their cause-bit position
    task automatic drive_event(input int i, input logic v);
        case (i)
            BIT_VDET: vdetIn <= v;
            BIT_WDT: wdtIn <= v;
            BIT_SYSCLK: lockIn <= v;
            BIT_TRIM: trimIn <= v;
            default: flashIn <= v;
        endcase
    endtask
    task automatic pulse(input int i);
        @(posedge clock);
        drive_event(i, 1'b1);
        @(posedge clock);
        drive_event(i, 1'b0);
    endtask
    // counts warm-up cycles until the cpu leaves reset, bounded
    task automatic await_run(output int warm);
        int k;
        warm = 0;
        k = 0;
        // let the edge that launched the reset settle before looking at outputs
        #1;
        while (cpuResetN !== 1'b1 && k < 3000) begin
            @(posedge clock);
            #1;
            if (trimLoadStart === 1'b1) loads++;
            if (warmupActive === 1'b1) begin
                warm++;
                chk(cpuResetN, 1'b0);
            end
            k++;
        end
        chk(periphResetN, 1'b1);
        if (k == 3000) err_count++;
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    //==============================================================
    // watchdog: the whole sequence needs well under 10000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        tally_and_finish();
    end
    //==============================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        chk(cpuResetN, 1'b0);
        chk(startVector, RESET_VECTOR_ADDR);
        await_run(n);
        chk(16'(n), 16'(WARM));
        rd(OFF_CAUSE_STATUS, 8'h00);
        rd(4'h3, 8'h00); // unmapped place reads zero
        // each factor sets its own flag and flags pile up
        for (int i = 0; i < NUM_FACTORS; i++) begin
            loads = 0;
            pulse(i);
            await_run(n);
            chk(16'(n), 16'(WARM));
            chk(16'(loads), 16'h0001);
            rd(OFF_CAUSE_STATUS, 8'((2 << i) - 1));
        end
        // clear key without the request bit does nothing; a wrong key neither
        wr(OFF_PROTECT_KEY, KEY_CAUSE_CLEAR);
        rd(OFF_CAUSE_STATUS, 8'h1f);
        wr(OFF_CAUSE_STATUS, 8'hff);
        rd(OFF_CAUSE_STATUS, 8'h5f);
        wr(OFF_PROTECT_KEY, 8'h55);
        rd(OFF_CAUSE_STATUS, 8'h5f);
        wr(OFF_PROTECT_KEY, KEY_CAUSE_CLEAR);
        rd(OFF_CAUSE_STATUS, 8'h00);
        // bad trim data flagged, then reloaded by a clock-deadlock reset
        @(posedge clock);
        trimLoadBad <= 1'b1;
        pulse(BIT_SYSCLK);
        await_run(n);
        rd(OFF_CAUSE_STATUS, 8'h24);
        @(posedge clock);
        trimLoadBad <= 1'b0;
        pulse(BIT_SYSCLK);
        await_run(n);
        rd(OFF_CAUSE_STATUS, 8'h04);
        // a second reset in mid warm-up restarts the count from zero
        pulse(BIT_WDT);
        repeat (WARM / 2) @(posedge clock);
        pulse(BIT_WDT);
        await_run(n);
        chk(16'(n), 16'(WARM));
        // a short low on the pin is ignored, a long one resets and clears causes
        partner.hold_pin_low(300);
        repeat (4) @(posedge clock);
        #1;
        chk(cpuResetN, 1'b1);
        rd(OFF_CAUSE_STATUS, 8'h06);
        // a factor event in the same cycle as the clear key keeps its flag
        wr(OFF_CAUSE_STATUS, 8'h40);
        @(posedge clock);
        regAddr <= OFF_PROTECT_KEY;
        regWdata <= KEY_CAUSE_CLEAR;
        regWr <= 1'b1;
        wdtIn <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
        wdtIn <= 1'b0;
        await_run(n);
        rd(OFF_CAUSE_STATUS, 8'h02);
        partner.hold_pin_low(700);
        await_run(n);
        chk(16'(n), 16'(WARM));
        rd(OFF_CAUSE_STATUS, 8'h00);
        // supply dip overlapping a longer pin low: warm-up waits for the pin
        pulse(BIT_WDT);
        await_run(n);
        fork
            partner.supply_dip(20);
            partner.hold_pin_low(700);
            begin
                repeat (300) @(posedge clock);
                #1;
                chk(cpuResetN, 1'b0);
                chk(warmupActive, 1'b0);
            end
        join
        #1;
        chk(cpuResetN, 1'b0);
        await_run(n);
        chk(16'(n), 16'(WARM));
        rd(OFF_CAUSE_STATUS, 8'h00);
        // pin becomes a port bit; switch only while the pin is high
        wr(OFF_SYS_CTL_THREE, 8'h01);
        rd(OFF_SYS_CTL_THREE, 8'h01);
        wr(OFF_PROTECT_KEY, KEY_PIN_FUNCTION);
        fork
            partner.hold_pin_low(700);
            begin
                repeat (680) @(posedge clock);
                #1;
                chk(portPinData, 1'b0);
                chk(cpuResetN, 1'b1);
            end
        join
        repeat (4) @(posedge clock);
        #1;
        chk(portPinData, 1'b1);
        // back to reset function with the same key
        wr(OFF_SYS_CTL_THREE, 8'h00);
        wr(OFF_PROTECT_KEY, KEY_PIN_FUNCTION);
        partner.hold_pin_low(700);
        await_run(n);
        chk(16'(n), 16'(WARM));
        // power application brings the pin back as reset input
        wr(OFF_SYS_CTL_THREE, 8'h01);
        wr(OFF_PROTECT_KEY, KEY_PIN_FUNCTION);
        partner.supply_dip(20);
        await_run(n);
        partner.hold_pin_low(700);
        await_run(n);
        chk(16'(n), 16'(WARM));
        chk(portPinData, 1'b0);
        tally_and_finish();
    end
endmodule // reset_source_combiner_tb
